/* io_slot_remap_table.sv */
// slot remapping unit: record intake, table lookup and backplane redirection
`timescale 1ns/1ns
module io_slot_remap_table (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic free_slot_remap,
  input wire logic [63:0] bp_present,
  input wire logic [63:0] planned_present,
  input wire slot_remap_pkg::io_req_t acc_req,
  input wire logic [7:0] bp_rdata,
  input wire slot_remap_pkg::rec_wr_t rec_wr,
  input wire slot_remap_pkg::rec_rd_t rec_rd,
  output slot_remap_pkg::io_req_t bp_req_q,
  output logic acc_done_q,
  output logic [7:0] acc_rdata_q,
  output logic rd_done_q,
  output logic [7:0] rd_data_q,
  output logic wr_ok_q,
  output logic wr_err_q,
  output logic commit_q,
  output logic mismatch_q
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------

  // entry codes that a table may legally hold
  function automatic logic entry_ok(input logic [7:0] b);
    entry_ok = (b <= slot_remap_pkg::ENTRY_SLOT_MAX) || (b == slot_remap_pkg::ENTRY_VIRTUAL);
  endfunction

  // slot numbers run 1 to 64; anything else is no slot
  function automatic logic slot_in_range(input logic [6:0] s);
    slot_in_range = (s != 7'h00) && (s <= slot_remap_pkg::SLOT_COUNT);
  endfunction

  // table entry of a target slot, ignore code when out of range
  function automatic logic [7:0] lookup(input slot_remap_pkg::table_t t, input logic [6:0] s);
    logic [6:0] i;
    i = s - 7'h01;
    lookup = slot_in_range(s) ? t[i[5:0]] : slot_remap_pkg::ENTRY_IGNORE;
  endfunction

  // module present at a physical slot
  function automatic logic slot_present(input logic [63:0] p, input logic [6:0] s);
    logic [6:0] i;
    i = s - 7'h01;
    slot_present = slot_in_range(s) && p[i[5:0]];
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic en;
    slot_remap_pkg::wr_state_t wr_st;
    logic [6:0] cnt;
    logic bad;
    slot_remap_pkg::table_t shadow;
    slot_remap_pkg::io_req_t bp;
    logic acc_pend;
    logic acc_done;
    logic [7:0] acc_rdata;
    logic rd_done;
    logic [7:0] rd_data;
    logic wr_ok;
    logic wr_err;
    logic commit;
    logic mismatch;
  } state_t;

  state_t q;
  state_t d;

  slot_remap_pkg::table_t tbl;
  slot_remap_pkg::table_t new_table;
  logic tbl_valid;
  logic remap_on;
  logic [7:0] entry;
  logic [6:0] phys;
  logic fwd;
  logic take;
  logic finishing;
  logic rec_ok;
  logic tbl_differs;
  logic nv_we;
  logic [7:0] rd_peek;
  logic [6:0] cnt_b;
  logic bad_b;

  // active table, held in retentive flops
  remap_store u_store (
    .core_clk(core_clk),
    .we(nv_we),
    .wdata(new_table),
    .table_q(tbl),
    .valid_q(tbl_valid)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    d.acc_done = 1'b0;
    d.rd_done = 1'b0;
    d.wr_ok = 1'b0;
    d.wr_err = 1'b0;
    d.commit = 1'b0;
    take = 1'b0;
    finishing = 1'b0;
    rec_ok = 1'b0;
    nv_we = 1'b0;
    cnt_b = q.cnt;
    bad_b = q.bad;
    new_table = q.shadow;

    // enable follows its parameter, cleared by reset
    d.en = free_slot_remap; // RL1
    remap_on = q.en && tbl_valid;

    // access redirection through the table
    entry = lookup(tbl, acc_req.slot); // RL2
    phys = remap_on ? entry[6:0] : acc_req.slot;
    fwd = 1'b1;
    if (remap_on && (entry == slot_remap_pkg::ENTRY_IGNORE)) begin
      fwd = 1'b0; // RL3
    end
    if (remap_on && (entry == slot_remap_pkg::ENTRY_VIRTUAL)) begin
      fwd = 1'b0; // RL5 RL6
    end
    if (!slot_present(bp_present, phys)) begin
      fwd = 1'b0; // RL8 RL9
    end
    d.bp = '0;
    if (acc_req.valid && fwd) begin
      d.bp.valid = 1'b1;
      d.bp.write = acc_req.write;
      d.bp.slot = phys; // RL4
      d.bp.data = acc_req.data;
    end

    // answer one cycle after the backplane cycle, zero unless truly read
    d.acc_pend = acc_req.valid;
    d.acc_done = q.acc_pend;
    d.acc_rdata = (q.acc_pend && q.bp.valid && !q.bp.write) ? bp_rdata : 8'h00; // RL5 RL9

    // partial record read of the active table
    rd_peek = tbl[rec_rd.byte_sel];
    d.rd_done = rec_rd.valid; // RL11
    d.rd_data = rd_peek;

    // layout check result
    d.mismatch = remap_on ? 1'b0 : (planned_present != bp_present); // RL7

    // record intake
    if (rec_wr.valid && rec_wr.first) begin
      if ((rec_wr.addr == slot_remap_pkg::DIAG_ADDR)
          && (rec_wr.index == slot_remap_pkg::REC_INDEX)) begin
        take = 1'b1; // RL13
        cnt_b = 7'h00;
        bad_b = 1'b0;
      end else begin
        d.wr_st = rec_wr.last ? slot_remap_pkg::WR_IDLE : slot_remap_pkg::WR_SKIP;
      end
    end else if (rec_wr.valid) begin
      unique case (q.wr_st)
        slot_remap_pkg::WR_IDLE: begin
          d.wr_st = slot_remap_pkg::WR_IDLE;
        end
        slot_remap_pkg::WR_FILL: begin
          take = 1'b1;
        end
        slot_remap_pkg::WR_SKIP: begin
          if (rec_wr.last) begin
            d.wr_st = slot_remap_pkg::WR_IDLE;
          end
        end
        default: begin
          d.wr_st = slot_remap_pkg::WR_IDLE;
        end
      endcase
    end

    if (take) begin
      if (cnt_b[6]) begin
        bad_b = 1'b1; // RL11
      end else begin
        new_table[cnt_b[5:0]] = rec_wr.data;
        bad_b = bad_b || !entry_ok(rec_wr.data); // RL15
      end
      d.shadow = new_table;
      d.cnt = cnt_b[6] ? cnt_b : cnt_b + 7'h01;
      d.bad = bad_b;
      d.wr_st = slot_remap_pkg::WR_FILL;
      if (rec_wr.last) begin
        finishing = 1'b1;
        rec_ok = (cnt_b == slot_remap_pkg::LAST_BYTE) && !bad_b; // RL11 RL15
        d.wr_st = slot_remap_pkg::WR_IDLE;
      end
    end

    // commit only what differs from the stored table
    // a store never written (valid bit unknown or low) always counts as different
    if (tbl_valid && (new_table == tbl)) begin
      tbl_differs = 1'b0;
    end else begin
      tbl_differs = 1'b1;
    end
    if (finishing && rec_ok) begin
      nv_we = tbl_differs; // RL12 RL13
      d.commit = tbl_differs;
      d.wr_ok = 1'b1;
    end
    if (finishing && !rec_ok) begin
      d.wr_err = 1'b1; // RL15
    end
  end

  // state register with synchronous reset
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      q <= '0;
      q.wr_st <= slot_remap_pkg::WR_IDLE;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign bp_req_q = q.bp;
  assign acc_done_q = q.acc_done;
  assign acc_rdata_q = q.acc_rdata;
  assign rd_done_q = q.rd_done;
  assign rd_data_q = q.rd_data;
  assign wr_ok_q = q.wr_ok;
  assign wr_err_q = q.wr_err;
  assign commit_q = q.commit;
  assign mismatch_q = q.mismatch;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  sequence virt_read;
    acc_req.valid && !acc_req.write && remap_on && (entry == slot_remap_pkg::ENTRY_VIRTUAL);
  endsequence

  sequence good_end;
    finishing && rec_ok;
  endsequence

  sequence bad_end;
    finishing && !rec_ok;
  endsequence

  a_disabled_passthru: assert property ( // RL1
    acc_req.valid && !q.en && slot_present(bp_present, acc_req.slot)
    |=> bp_req_q.valid && (bp_req_q.slot == $past(acc_req.slot)))
    else $error("disabled remap did not pass slot through");

  a_ignored_nodrive: assert property ( // RL3
    acc_req.valid && remap_on && (entry == slot_remap_pkg::ENTRY_IGNORE) |=> !bp_req_q.valid)
    else $error("ignored slot reached backplane");

  a_redirect_slot: assert property ( // RL4
    acc_req.valid && remap_on && (entry != 8'h00) && (entry <= 8'h40)
    && slot_present(bp_present, entry[6:0])
    |=> bp_req_q.valid && (bp_req_q.slot == $past(phys)) && ($past(phys) == $past(entry[6:0])))
    else $error("access not redirected to mapped slot");

  a_virtual_zero: assert property ( // RL5
    virt_read |=> !bp_req_q.valid ##1 acc_done_q && (acc_rdata_q == 8'h00))
    else $error("virtual module input not zero");

  a_virtual_nowrite: assert property ( // RL6
    acc_req.valid && acc_req.write && remap_on && (entry == slot_remap_pkg::ENTRY_VIRTUAL)
    |=> !bp_req_q.valid)
    else $error("virtual module write reached backplane");

  a_startup_match: assert property ( // RL7
    remap_on |=> !mismatch_q)
    else $error("layout mismatch reported while remapping");

  a_missing_drop: assert property ( // RL8
    acc_req.valid && acc_req.write && !slot_present(bp_present, phys) |=> !bp_req_q.valid)
    else $error("write to missing module driven");

  a_missing_zero: assert property ( // RL9
    acc_req.valid && !acc_req.write && !slot_present(bp_present, phys)
    |=> ##1 acc_done_q && (acc_rdata_q == 8'h00))
    else $error("missing module input not zero");

  a_commit_differs: assert property ( // RL12
    good_end |=> wr_ok_q && (commit_q == $past(tbl_differs)) && (tbl == $past(new_table)))
    else $error("valid table not committed as required");

  a_reject_keeps: assert property ( // RL15
    bad_end |=> wr_err_q && !wr_ok_q && $stable(tbl) && !commit_q)
    else $error("rejected table changed active table");

  a_read_part: assert property ( // RL11
    rec_rd.valid |=> rd_done_q && (rd_data_q == $past(rd_peek)))
    else $error("record read returned wrong byte");

endmodule

/* slot_remap_pkg.sv */
// constants, carriers and states shared by the slot remapping unit
//
// Behaviour
// RL1: remapping stays off after reset until its enable parameter is set.
// RL2: table is a 64 byte record, index 0x7f; byte n maps target slot n+1.
// RL3: entry 0x00 ignores the target slot, so the layout may hold gaps.
// RL4: entries 0x01 to 0x40 redirect every access to that physical slot.
// RL5: entry 0xff makes a virtual module whose inputs always read zero.
// RL6: writes to a virtual module output area are discarded.
// RL7: with remapping on and a valid table, start-up reports no layout mismatch.
// RL8: output data for a missing physical module is dropped, never driven.
// RL9: input data of a missing physical module reads as all zeros.
// RL10: the table sits in retentive storage that survives power loss and restart.
// RL11: writer sends all 64 bytes at once; reads may fetch single table bytes.
// RL12: a valid table is committed to storage only when it differs.
// RL13: a valid record at the diagnostic address is stored and active at once.
// RL14: configuring party must also allow start-up with differing layouts.
// RL15: any entry 0x41 to 0xfe rejects the write; old table stays in force.
package slot_remap_pkg;

  // ----------------------------------------------------------------
  // record layout and entry encodings
  // ----------------------------------------------------------------
  localparam logic [7:0] REC_INDEX = 8'h7f;
  localparam logic [15:0] DIAG_ADDR = 16'h0100; // arbitrary diagnostic address
  localparam logic [6:0] LAST_BYTE = 7'h3f;
  localparam logic [6:0] SLOT_COUNT = 7'h40;
  localparam logic [7:0] ENTRY_IGNORE = 8'h00;
  localparam logic [7:0] ENTRY_SLOT_MAX = 8'h40;
  localparam logic [7:0] ENTRY_VIRTUAL = 8'hff;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef logic [63:0][7:0] table_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [6:0] slot;
    logic [7:0] data;
  } io_req_t;

  typedef struct packed {
    logic valid;
    logic first;
    logic last;
    logic [15:0] addr;
    logic [7:0] index;
    logic [7:0] data;
  } rec_wr_t;

  typedef struct packed {
    logic valid;
    logic [5:0] byte_sel;
  } rec_rd_t;

  typedef enum logic [2:0] {
    WR_IDLE = 3'b001,
    WR_FILL = 3'b010,
    WR_SKIP = 3'b100
  } wr_state_t;

endpackage

/* remap_store.sv */
// retentive holding store for the active remap table
`timescale 1ns/1ns
module remap_store (
  input wire logic core_clk,
  input wire logic we,
  input wire slot_remap_pkg::table_t wdata,
  output slot_remap_pkg::table_t table_q,
  output logic valid_q
);

  typedef struct packed {
    slot_remap_pkg::table_t tbl;
    logic valid;
  } store_t;

  store_t q;
  store_t d;

  // next contents: only a committed write changes them
  always_comb begin
    d = q;
    if (we) begin
      d.tbl = wdata;
      d.valid = 1'b1;
    end
  end

  // storage is deliberately outside the reset so it survives restart
  always_ff @(posedge core_clk) begin
    q <= d; // RL10
  end

  assign table_q = q.tbl;
  assign valid_q = q.valid;

endmodule

/* io_modules.sv */
// behavioural backplane modules answering forwarded reads and taking writes
`timescale 1ns/1ns
module io_modules (
  input wire logic core_clk,
  input wire slot_remap_pkg::io_req_t req,
  output logic [7:0] rdata
);
  logic [7:0] mem [0:127];
  logic [7:0] last_q = 8'h00;
  // data only while a read is shown; otherwise a pattern that keeps changing
  always_comb begin
    rdata = ~last_q;
    if (req.valid && !req.write) begin
      rdata = mem[req.slot];
    end
  end
  // forwarded writes land in the addressed module
  always @(posedge core_clk) begin
    last_q <= rdata;
    if (req.valid && req.write) begin
      mem[req.slot] <= req.data;
    end
  end
  // each module starts with a distinct pattern
  initial begin
    for (int i = 0; i < 128; i++) mem[i] = 8'(i * 3);
  end
endmodule

/* testbench.sv */
// self-checking testbench of the slot remapping unit
`timescale 1ns/1ns
module testbench;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic free_slot_remap = 1'b0;
  logic [63:0] bp_present;
  logic [63:0] planned_present = '1;
  slot_remap_pkg::io_req_t acc_req = '0;
  slot_remap_pkg::rec_wr_t rec_wr = '0;
  slot_remap_pkg::rec_rd_t rec_rd = '0;
  slot_remap_pkg::io_req_t bp_req_q;
  logic [7:0] bp_rdata;
  logic acc_done_q, rd_done_q, wr_ok_q, wr_err_q, commit_q, mismatch_q;
  logic [7:0] acc_rdata_q;
  logic [7:0] rd_data_q;
  int err_total = 0;
  int n_checks = 0;
  int seed = 13171;
  int tab[64];
  int nt[64];
  int pm[128];
  bit tvalid = 0;
  bit en = 0;

  // ----------------------------------------------------------------
  // clock, design and backplane
  // ----------------------------------------------------------------
  always #10 core_clk = ~core_clk;

  io_slot_remap_table dut (.core_clk(core_clk), .resetn(resetn),
    .free_slot_remap(free_slot_remap), .bp_present(bp_present),
    .planned_present(planned_present), .acc_req(acc_req), .bp_rdata(bp_rdata),
    .rec_wr(rec_wr), .rec_rd(rec_rd), .bp_req_q(bp_req_q), .acc_done_q(acc_done_q),
    .acc_rdata_q(acc_rdata_q), .rd_done_q(rd_done_q), .rd_data_q(rd_data_q),
    .wr_ok_q(wr_ok_q), .wr_err_q(wr_err_q), .commit_q(commit_q),
    .mismatch_q(mismatch_q));

  io_modules modules (.core_clk(core_clk), .req(bp_req_q), .rdata(bp_rdata));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic final_report;
    if (err_total == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // random table, optionally with one out-of-range entry
  task automatic gen(input bit bad);
    int r;
    for (int k = 0; k < 64; k++) begin
      r = {$random(seed)} % 8;
      nt[k] = (r == 0) ? 0 : (r == 7) ? 255 : 1 + {$random(seed)} % 64;
    end
    if (bad) nt[{$random(seed)} % 64] = 65 + {$random(seed)} % 190;
  endtask

  // send n bytes of nt as one record and judge the answer
  task automatic rec_write(input int n);
    bit diff;
    bit good;
    diff = !tvalid;
    good = (n == 64);
    for (int k = 0; k < n; k++) begin
      rec_wr = '{1'b1, k == 0, k == n - 1, slot_remap_pkg::DIAG_ADDR,
        slot_remap_pkg::REC_INDEX, 8'(nt[k])};
      if (nt[k] != tab[k]) diff = 1;
      if (nt[k] > 64 && nt[k] < 255) good = 0;
      @(posedge core_clk); #1;
    end
    rec_wr.valid = 1'b0;
    chk("wr ok", 8'(good), 8'(wr_ok_q));
    chk("wr err", 8'(!good), 8'(wr_err_q));
    chk("commit", 8'(good && diff), 8'(commit_q));
    if (good) begin
      tab = nt;
      tvalid = 1;
    end
    @(posedge core_clk); #1;
  endtask

  // one access through the unit, checked against the reference model
  task automatic access(input logic [6:0] s, input logic w, input logic [7:0] d);
    int ph;
    bit fwd;
    int e;
    ph = s;
    fwd = 1;
    if (en && tvalid) begin
      if (s == 0 || s > 64) fwd = 0;
      else ph = tab[s - 1];
    end
    if (ph < 1 || ph > 64) fwd = 0;
    else if (!bp_present[ph - 1]) fwd = 0;
    e = (fwd && !w) ? pm[ph] : 0;
    acc_req = '{1'b1, w, s, d};
    @(posedge core_clk); #1;
    acc_req.valid = 1'b0;
    chk("bp valid", 8'(fwd), 8'(bp_req_q.valid));
    if (fwd) begin
      chk("bp slot", 8'(ph), 8'(bp_req_q.slot));
      chk("bp write", 8'(w), 8'(bp_req_q.write));
      if (w) chk("bp data", d, bp_req_q.data);
      if (w) pm[ph] = d;
    end
    @(posedge core_clk); #1;
    chk("acc done", 8'h01, 8'(acc_done_q));
    chk("acc rdata", 8'(e), acc_rdata_q);
    chk("mismatch", 8'(!(en && tvalid) && planned_present != bp_present), 8'(mismatch_q));
  endtask

  task automatic rd_check(input int s);
    rec_rd = '{1'b1, 6'(s)};
    @(posedge core_clk); #1;
    rec_rd.valid = 1'b0;
    chk("rd done", 8'h01, 8'(rd_done_q));
    chk("rd data", 8'(tab[s]), rd_data_q);
    @(posedge core_clk); #1;
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    bp_present = {$random(seed), $random(seed)} | 64'h0f;
    for (int i = 0; i < 128; i++) pm[i] = (i * 3) & 255;
    repeat (3) @(posedge core_clk);
    #1 resetn = 1'b1;
    @(posedge core_clk); #1;
    chk("reset outs", 8'h00, {2'b00, bp_req_q.valid, acc_done_q, rd_done_q, wr_ok_q, wr_err_q,
      commit_q});
    chk("reset mismatch", 8'(planned_present != bp_present), 8'(mismatch_q));
    gen(0);
    rec_write(64);
    rec_write(64);
    repeat (40) access(7'(1 + {$random(seed)} % 64), 1'($random(seed)), 8'($random(seed)));
    free_slot_remap = 1'b1;
    en = 1;
    repeat (2) @(posedge core_clk);
    #1;
    repeat (300) access(7'({$random(seed)} % 71), 1'($random(seed)), 8'($random(seed)));
    gen(1);
    rec_write(64);
    gen(0);
    rec_write(63);
    repeat (100) access(7'({$random(seed)} % 71), 1'($random(seed)), 8'($random(seed)));
    gen(0);
    rec_write(64);
    repeat (100) access(7'({$random(seed)} % 71), 1'($random(seed)), 8'($random(seed)));
    for (int s = 0; s < 64; s++) rd_check(s);
    // second reset: the enable drops, the table survives
    resetn = 1'b0;
    free_slot_remap = 1'b0;
    en = 0;
    // matching layouts from here on, so a clean layout check is seen too
    planned_present = bp_present;
    repeat (2) @(posedge core_clk);
    #1 resetn = 1'b1;
    @(posedge core_clk); #1;
    chk("reset outs", 8'h00, {2'b00, bp_req_q.valid, acc_done_q, rd_done_q, wr_ok_q, wr_err_q,
      commit_q});
    chk("reset mismatch", 8'h00, 8'(mismatch_q));
    repeat (20) rd_check({$random(seed)} % 64);
    repeat (20) access(7'(1 + {$random(seed)} % 64), 1'($random(seed)), 8'($random(seed)));
    final_report;
  end

  initial begin
    #200000;
    err_total++;
    final_report;
  end
endmodule
